// ### verilog/dtt_pkg.sv
// Shared constants and types for the table travel drive link
package dtt_pkg;

  // Power-state control words
  localparam logic [15:0] CW_DISABLE = 16'h0000;
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE = 16'h000f;
  localparam logic [3:0] CW_NIBBLE_ENABLED = 4'hf;

  // Control word field positions
  localparam int CW_SEQ_BIT = 4;
  localparam int CW_RESUME_BIT = 6;
  localparam int CW_HALT_BIT = 8;
  localparam int CW_START_BIT = 9;
  localparam int CW_SEL_LSB = 11;

  // Status words and field positions
  localparam logic [15:0] SW_DISABLED = 16'h0050;
  localparam logic [15:0] SW_READY = 16'h0031;
  localparam logic [15:0] SW_SWITCHED = 16'h0033;
  localparam logic [15:0] SW_ENABLED = 16'h0237;
  localparam logic [7:0] SW_ENABLED_LOW = 8'h37;
  localparam int SW_PROGRESS_BIT = 8;
  localparam int SW_TARGET_BIT = 10;

  // Object indices
  localparam logic [15:0] OBJ_STATUS = 16'h6041;
  localparam logic [15:0] OBJ_MODE = 16'h6060;
  localparam logic [15:0] OBJ_MODE_DISP = 16'h6061;
  localparam logic [15:0] OBJ_ACTIVE = 16'h5ff0;
  localparam logic [15:0] OBJ_RESUME = 16'h5ff1;
  localparam logic [15:0] OBJ_ERROR = 16'h2104;
  localparam logic [15:0] OBJ_WARNING = 16'h210e;
  localparam logic [15:0] OBJ_DATASET = 16'h219e;
  localparam logic [3:0] OBJ_MFR_NIBBLE = 4'h2;

  // Values and reset values
  localparam logic [7:0] MODE_TABLE = 8'hff;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] DATASET_RST = 3'h0;
  localparam logic [2:0] DATASET_MAX = 3'h4;
  localparam logic [7:0] BLK_NONE = 8'hff;
  localparam logic [7:0] BLK_LAST = 8'h20;

  // Controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OBJ_INDEX = 8'h04;
  localparam logic [7:0] REG_OBJ_DATA = 8'h08;
  localparam logic [7:0] REG_OBJ_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_OBJ_RESULT = 8'h14;
  localparam logic [7:0] REG_SEQ = 8'h18;

  typedef enum logic [3:0] {
    PS_DISABLED = 4'b0001,
    PS_READY = 4'b0010,
    PS_SWITCHED = 4'b0100,
    PS_ENABLED = 4'b1000
  } dtt_pwr_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_MOVE = 2'b10
  } dtt_seq_t;

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_OFF = 5'b00010,
    HS_SHUT = 5'b00100,
    HS_ON = 5'b01000,
    HS_EN = 5'b10000
  } dtt_hseq_t;

  function automatic logic dtt_low_eq(input logic [15:0] word, input logic [7:0] pat);
    dtt_low_eq = (word[7:0] == pat);
  endfunction : dtt_low_eq

endpackage : dtt_pkg

// ### verilog/dtt_link_if.sv
// Fieldbus link between controller and drive
`timescale 1ns/1ps
interface dtt_link_if;
  logic [15:0] ctrl_word;
  logic ctrl_valid;
  logic [15:0] status_word;
  logic obj_req;
  logic obj_we;
  logic [15:0] obj_index;
  logic [15:0] obj_wdata;
  logic obj_ack;
  logic obj_err;
  logic [15:0] obj_rdata;

  modport drive (
    input ctrl_word, ctrl_valid, obj_req, obj_we, obj_index, obj_wdata,
    output status_word, obj_ack, obj_err, obj_rdata
  );

  modport plc (
    output ctrl_word, ctrl_valid, obj_req, obj_we, obj_index, obj_wdata,
    input status_word, obj_ack, obj_err, obj_rdata
  );
endinterface : dtt_link_if

// ### verilog/dtt_block_seq.sv
// Motion block sequencer: single blocks, chains, interrupt and resume
`timescale 1ns/1ps
module dtt_block_seq
  import dtt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Commands from control word decode
  input wire logic start,
  input wire logic seq,
  input wire logic resume,
  input wire logic [4:0] select,
  input wire logic interrupt,
  input wire logic abort,
  input wire logic halt,
  // Axis feedback
  input wire logic in_position,
  input wire logic axis_standstill,
  input wire logic [7:0] next_block,
  // State
  output logic [5:0] active_block,
  output logic in_progress,
  output logic target_reached,
  output logic [7:0] resume_block
);

  dtt_seq_t state_q;
  logic [5:0] blk_q;
  logic seq_q;
  logic tgt_q;
  logic [7:0] resume_q;

  wire resume_ok = resume && (resume_q != BLK_NONE);
  wire [5:0] sel_blk = {1'b0, select} + 6'h01;
  wire [5:0] start_blk = resume_ok ? resume_q[5:0] : sel_blk;
  // Zero ends a chain; negative settings are end-with-error codes (here they end it like zero, with target reached and no error)
  wire next_ok = !next_block[7] && (next_block != 8'h00) && (next_block <= BLK_LAST);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= SQ_IDLE;
      blk_q <= 6'h00;
      seq_q <= 1'b0;
      tgt_q <= 1'b0;
      resume_q <= BLK_NONE;
    end
    else
    begin
      case (state_q)
        SQ_IDLE:
          if (start)
          begin
            state_q <= SQ_MOVE;
            blk_q <= start_blk;
            seq_q <= seq;
            tgt_q <= 1'b0;
            resume_q <= BLK_NONE;
          end
        SQ_MOVE:
          if (interrupt || abort)
          begin
            state_q <= SQ_IDLE;
            tgt_q <= 1'b0;
            resume_q <= interrupt ? {2'b00, blk_q} : BLK_NONE;
          end
          else if (halt)
            tgt_q <= axis_standstill;
          else if (in_position)
          begin
            if (seq_q && next_ok)
            begin
              blk_q <= next_block[5:0];
              tgt_q <= 1'b0;
            end
            else
            begin
              state_q <= SQ_IDLE;
              tgt_q <= 1'b1;
            end
          end
          else
            tgt_q <= 1'b0;
        default:
          state_q <= SQ_IDLE;
      endcase
    end
  end

  assign active_block = blk_q;
  assign in_progress = (state_q == SQ_MOVE);
  assign target_reached = tgt_q;
  assign resume_block = resume_q;

endmodule : dtt_block_seq

// ### verilog/dtt_drive.sv
// Drive end: power states, control word decode, objects, status word
`timescale 1ns/1ps
module dtt_drive
  import dtt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fieldbus link
  dtt_link_if.drive link,
  // Axis feedback
  input wire logic in_position,
  input wire logic axis_standstill,
  input wire logic [7:0] next_block,
  // Fault reporting
  input wire logic [15:0] fault_code,
  input wire logic [15:0] warning_code,
  // Drive control
  output logic power_on,
  output logic motion_enable,
  output logic halt_axis,
  output logic [5:0] active_block,
  output logic [2:0] data_set
);

  dtt_pwr_t pwr_q;
  dtt_pwr_t pwr_d;
  logic [15:0] cw_q;
  logic [15:0] status_q;
  logic [7:0] mode_q;
  logic [2:0] dset_q;
  logic ack_q;
  logic err_q;
  logic [15:0] rdata_q;
  logic in_progress;
  logic target_reached;
  logic [7:0] resume_block;

  // Control word decode
  wire take = link.ctrl_valid;
  wire [15:0] cw_new = link.ctrl_word;
  wire nibble_en = (cw_new[3:0] == CW_NIBBLE_ENABLED);
  wire enabled = (pwr_q == PS_ENABLED);
  wire table_mode = (mode_q == MODE_TABLE);
  wire motion_ok = enabled && table_mode && take && nibble_en;
  wire start_rise = motion_ok && cw_new[CW_START_BIT] && !cw_q[CW_START_BIT];
  wire start_fall = motion_ok && !cw_new[CW_START_BIT] && cw_q[CW_START_BIT];
  wire leave_en = enabled && (pwr_d != PS_ENABLED);
  wire halt_now = enabled && table_mode && cw_q[CW_HALT_BIT];

  // Power-state sequence
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PS_DISABLED:
        if (take && cw_new == CW_SHUTDOWN)
          pwr_d = PS_READY;
      PS_READY:
        if (take && cw_new == CW_SWITCH_ON)
          pwr_d = PS_SWITCHED;
        else if (take && cw_new == CW_DISABLE)
          pwr_d = PS_DISABLED;
      PS_SWITCHED:
        if (take && nibble_en)
          pwr_d = PS_ENABLED;
        else if (take && cw_new == CW_SHUTDOWN)
          pwr_d = PS_READY;
        else if (take && cw_new == CW_DISABLE)
          pwr_d = PS_DISABLED;
      PS_ENABLED:
        if (take && !nibble_en)
        begin
          if (cw_new == CW_SWITCH_ON)
            pwr_d = PS_SWITCHED;
          else if (cw_new == CW_SHUTDOWN)
            pwr_d = PS_READY;
          else
            pwr_d = PS_DISABLED;
        end
      default:
        pwr_d = PS_DISABLED;
    endcase
  end

  // Status word
  wire [15:0] status_en = SW_ENABLED
    | ({15'h0000, in_progress} << SW_PROGRESS_BIT)
    | ({15'h0000, target_reached} << SW_TARGET_BIT);
  wire [15:0] status_d =
    (pwr_q == PS_READY) ? SW_READY :
    (pwr_q == PS_SWITCHED) ? SW_SWITCHED :
    enabled ? status_en : SW_DISABLED;

  // Object access decode
  wire [15:0] idx = link.obj_index;
  wire [15:0] wdat = link.obj_wdata;
  wire obj_go = link.obj_req && !ack_q;
  wire mfr = (idx[15:12] == OBJ_MFR_NIBBLE);
  wire is_mode = (idx == OBJ_MODE);
  wire is_dset = (idx == OBJ_DATASET);
  // Mode and data set are run-protected: frozen while enabled
  wire wr_mode = obj_go && link.obj_we && is_mode && !enabled;
  wire wr_dset = obj_go && link.obj_we && is_dset && !enabled && (wdat[15:3] == 13'h0000)
    && (wdat[2:0] <= DATASET_MAX);
  wire wr_ok = wr_mode || wr_dset;
  wire rd_status = (idx == OBJ_STATUS);
  wire rd_disp = (idx == OBJ_MODE_DISP) || is_mode;
  wire rd_active = (idx == OBJ_ACTIVE);
  wire rd_resume = (idx == OBJ_RESUME);
  wire rd_err = mfr && (idx == OBJ_ERROR);
  wire rd_warn = mfr && (idx == OBJ_WARNING);
  wire rd_hit = rd_status || rd_disp || rd_active || rd_resume || rd_err || rd_warn || is_dset;
  wire [15:0] rdata_d =
    rd_status ? status_q :
    rd_disp ? {{8{mode_q[7]}}, mode_q} :
    rd_active ? {10'h000, active_block} :
    rd_resume ? {{8{resume_block[7]}}, resume_block} :
    rd_err ? fault_code :
    rd_warn ? warning_code :
    is_dset ? {13'h0000, dset_q} : 16'h0000;
  wire obj_fail = link.obj_we ? !wr_ok : !rd_hit;

  dtt_block_seq i_dtt_block_seq (
    .clk(clk),
    .reset(reset),
    .start(start_rise),
    .seq(cw_new[CW_SEQ_BIT]),
    .resume(cw_new[CW_RESUME_BIT]),
    .select(cw_new[15:CW_SEL_LSB]),
    .interrupt(start_fall),
    .abort(leave_en),
    .halt(halt_now),
    .in_position(in_position),
    .axis_standstill(axis_standstill),
    .next_block(next_block),
    .active_block(active_block),
    .in_progress(in_progress),
    .target_reached(target_reached),
    .resume_block(resume_block)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pwr_q <= PS_DISABLED;
      cw_q <= CW_DISABLE;
      status_q <= SW_DISABLED;
    end
    else
    begin
      pwr_q <= pwr_d;
      status_q <= status_d;
      if (take)
        cw_q <= cw_new;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_q <= MODE_RST;
      dset_q <= DATASET_RST;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ack_q <= obj_go;
      if (obj_go)
      begin
        err_q <= obj_fail;
        rdata_q <= link.obj_we ? 16'h0000 : rdata_d;
      end
      if (wr_mode)
        mode_q <= wdat[7:0];
      if (wr_dset)
        dset_q <= wdat[2:0];
    end
  end

  assign link.status_word = status_q;
  assign link.obj_ack = ack_q;
  assign link.obj_err = err_q;
  assign link.obj_rdata = rdata_q;
  assign power_on = (pwr_q == PS_SWITCHED) || enabled;
  assign motion_enable = in_progress;
  assign halt_axis = halt_now;
  assign data_set = dset_q;

endmodule : dtt_drive

// ### verilog/dtt_plc.sv
// Controller end: Wishbone registers, enable sequence, object requests
`timescale 1ns/1ps
module dtt_plc
  import dtt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Fieldbus link
  dtt_link_if.plc link
);

  dtt_hseq_t hs_q;
  dtt_hseq_t hs_d;
  logic [15:0] cw_q;
  logic cwv_q;
  logic [15:0] idx_q;
  logic [15:0] wdat_q;
  logic req_q;
  logic we_q;
  logic err_q;
  logic [15:0] res_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic seq_send;
  logic [15:0] seq_word;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // Bus decode
  wire acc = wb_cyc_i && wb_stb_i;
  wire wr = acc && wb_we_i && ack_q;
  wire wr_ctrl = wr && (wb_adr_i == REG_CTRL) && (hs_q == HS_IDLE);
  wire wr_idx = wr && (wb_adr_i == REG_OBJ_INDEX);
  wire wr_dat = wr && (wb_adr_i == REG_OBJ_DATA);
  wire wr_cmd = wr && (wb_adr_i == REG_OBJ_CMD) && wb_sel_i[0] && wb_dat_i[0] && !req_q;
  wire wr_seq = wr && (wb_adr_i == REG_SEQ) && wb_sel_i[0] && wb_dat_i[0] && (hs_q == HS_IDLE);
  // Mode change only from the switched-on state; unsafe otherwise
  wire mode_block = wb_dat_i[1] && (idx_q == OBJ_MODE)
    && !dtt_low_eq(link.status_word, SW_SWITCHED[7:0]);
  wire [31:0] rd_status = {13'h0000, err_q, req_q, hs_q != HS_IDLE, link.status_word};
  wire [31:0] rd_d =
    (wb_adr_i == REG_CTRL) ? {16'h0000, cw_q} :
    (wb_adr_i == REG_OBJ_INDEX) ? {16'h0000, idx_q} :
    (wb_adr_i == REG_OBJ_DATA) ? {16'h0000, wdat_q} :
    (wb_adr_i == REG_STATUS) ? rd_status :
    (wb_adr_i == REG_OBJ_RESULT) ? {16'h0000, res_q} : 32'h0000_0000;

  // Enable sequence: each word waits for its status answer
  always_comb
  begin
    hs_d = hs_q;
    seq_send = 1'b0;
    seq_word = cw_q;
    case (hs_q)
      HS_IDLE:
        if (wr_seq)
        begin
          hs_d = HS_OFF;
          seq_send = 1'b1;
          seq_word = CW_DISABLE;
        end
      HS_OFF:
        if (!cwv_q && dtt_low_eq(link.status_word, SW_DISABLED[7:0]))
        begin
          hs_d = HS_SHUT;
          seq_send = 1'b1;
          seq_word = CW_SHUTDOWN;
        end
      HS_SHUT:
        if (!cwv_q && dtt_low_eq(link.status_word, SW_READY[7:0]))
        begin
          hs_d = HS_ON;
          seq_send = 1'b1;
          seq_word = CW_SWITCH_ON;
        end
      HS_ON:
        if (!cwv_q && dtt_low_eq(link.status_word, SW_SWITCHED[7:0]))
        begin
          hs_d = HS_EN;
          seq_send = 1'b1;
          seq_word = CW_ENABLE;
        end
      HS_EN:
        if (!cwv_q && dtt_low_eq(link.status_word, SW_ENABLED_LOW))
          hs_d = HS_IDLE;
      default:
        hs_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hs_q <= HS_IDLE;
      cw_q <= CW_DISABLE;
      cwv_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      hs_q <= hs_d;
      cwv_q <= seq_send || wr_ctrl;
      ack_q <= acc && !ack_q;
      if (acc && !ack_q)
        dat_q <= rd_d;
      // Word is held on the link until replaced, keeping the start bit up
      if (seq_send)
        cw_q <= seq_word;
      else if (wr_ctrl)
        cw_q <= merge16(cw_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      idx_q <= 16'h0000;
      wdat_q <= 16'h0000;
      req_q <= 1'b0;
      we_q <= 1'b0;
      err_q <= 1'b0;
      res_q <= 16'h0000;
    end
    else
    begin
      if (wr_idx)
        idx_q <= merge16(idx_q, wb_dat_i, wb_sel_i);
      if (wr_dat)
        wdat_q <= merge16(wdat_q, wb_dat_i, wb_sel_i);
      if (wr_cmd && mode_block)
        err_q <= 1'b1;
      else if (wr_cmd)
      begin
        req_q <= 1'b1;
        we_q <= wb_dat_i[1];
        err_q <= 1'b0;
      end
      else if (req_q && link.obj_ack)
      begin
        req_q <= 1'b0;
        err_q <= link.obj_err;
        res_q <= link.obj_rdata;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign link.ctrl_word = cw_q;
  assign link.ctrl_valid = cwv_q;
  assign link.obj_req = req_q;
  assign link.obj_we = we_q;
  assign link.obj_index = idx_q;
  assign link.obj_wdata = wdat_q;

endmodule : dtt_plc

// ### bench/dtt_properties.sv
// Link checker for the table travel drive link
`timescale 1ns/1ps
module dtt_properties
  import dtt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link signals
  input wire logic [15:0] ctrl_word,
  input wire logic ctrl_valid,
  input wire logic [15:0] status_word,
  input wire logic obj_req,
  input wire logic obj_we,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [15:0] prev_q;
  logic [7:0] mode_q;
  wire rise9 = ctrl_valid && ctrl_word[9] && !prev_q[9];
  wire fall9 = ctrl_valid && !ctrl_word[9] && prev_q[9];
  wire on = (status_word[7:0] == SW_ENABLED_LOW);
  wire obj_new = obj_req && !obj_ack;
  wire mode_ok = obj_req && obj_we && obj_ack && !obj_err && obj_index == OBJ_MODE;
  // Shadow of the last taken word and mode, for edge and mode qualifiers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prev_q <= CW_DISABLE;
      mode_q <= MODE_RST;
    end
    else
    begin
      if (ctrl_valid)
        prev_q <= ctrl_word;
      if (mode_ok)
        mode_q <= obj_wdata[7:0];
    end
  end
  property p_ready;
    ctrl_valid && ctrl_word == CW_SHUTDOWN && status_word == SW_DISABLED |-> ##2 status_word == SW_READY;
  endproperty
  property p_switched;
    ctrl_valid && ctrl_word == CW_SWITCH_ON && status_word == SW_READY |-> ##2 status_word == SW_SWITCHED;
  endproperty
  property p_order;
    ctrl_valid && ctrl_word == CW_SWITCH_ON && status_word == SW_DISABLED |-> ##2 status_word == SW_DISABLED;
  endproperty
  property p_enable;
    ctrl_valid && ctrl_word[3:0] == CW_NIBBLE_ENABLED && status_word == SW_SWITCHED |-> ##2 on;
  endproperty
  property p_start;
    rise9 && ctrl_word[3:0] == CW_NIBBLE_ENABLED && on && mode_q == MODE_TABLE |-> ##2 on && status_word[10:8] == 3'h3;
  endproperty
  property p_stop;
    fall9 && on && status_word[8] |-> ##2 !status_word[8];
  endproperty
  property p_obj_answer;
    obj_new |=> obj_ack ##1 !obj_ack;
  endproperty
  property p_dataset_locked;
    obj_new && obj_we && obj_index == OBJ_DATASET && on |=> obj_ack && obj_err;
  endproperty
  property p_mfr_read;
    obj_new && !obj_we && (obj_index == OBJ_ERROR || obj_index == OBJ_WARNING) |=> obj_ack && !obj_err;
  endproperty
  property p_low_read;
    obj_new && !obj_we && obj_index[15:12] < OBJ_MFR_NIBBLE |=> obj_ack && obj_err;
  endproperty
  a_ready: assert property (p_ready) else $error("shutdown not answered");
  a_switched: assert property (p_switched) else $error("switch on not answered");
  a_order: assert property (p_order) else $error("out of order word moved state");
  a_enable: assert property (p_enable) else $error("enable not answered");
  a_start: assert property (p_start) else $error("start edge did not show progress");
  a_stop: assert property (p_stop) else $error("start drop did not stop block");
  a_obj_answer: assert property (p_obj_answer) else $error("object ack not one cycle");
  a_dataset_locked: assert property (p_dataset_locked) else $error("data set write taken while on");
  a_mfr_read: assert property (p_mfr_read) else $error("fault read refused");
  a_low_read: assert property (p_low_read) else $error("foreign read accepted");
  c_start: cover property (rise9 && on);
  c_stop: cover property (fall9 && status_word[8]);
  c_mode: cover property (mode_ok);
  c_halt: cover property (on && status_word[8] && status_word[10]);
endmodule : dtt_properties

// ### bench/drive_table_travel_control_bench.sv
// Testbench joining controller and drive ends
`timescale 1ns/1ps
module drive_table_travel_control_bench
  import dtt_pkg::*;
;
  typedef struct {logic [31:0] mask; logic [31:0] exp; string what;} dtt_note_t;
  logic clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, in_position, axis_standstill;
  logic power_on, motion_enable, halt_axis;
  logic [7:0] wb_adr, next_block;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  logic [15:0] fault_code, warning_code;
  logic [5:0] active_block;
  logic [2:0] data_set;
  logic [4:0] sels [5];
  int failures, samples_checked;
  dtt_note_t notes[$];
  dtt_note_t note;
  dtt_link_if link ();
  dtt_drive i_dtt_drive (.clk(clk), .reset(reset), .link(link), .in_position(in_position),
    .axis_standstill(axis_standstill), .next_block(next_block), .fault_code(fault_code),
    .warning_code(warning_code), .power_on(power_on), .motion_enable(motion_enable),
    .halt_axis(halt_axis), .active_block(active_block), .data_set(data_set));
  dtt_plc i_dtt_plc (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));
  dtt_properties i_dtt_properties (.clk(clk), .reset(reset), .ctrl_word(link.ctrl_word),
    .ctrl_valid(link.ctrl_valid), .status_word(link.status_word), .obj_req(link.obj_req),
    .obj_we(link.obj_we), .obj_index(link.obj_index), .obj_wdata(link.obj_wdata),
    .obj_ack(link.obj_ack), .obj_err(link.obj_err), .obj_rdata(link.obj_rdata));
  always #20 clk = ~clk;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Read notes are taken in order as acks come back
  always @(posedge clk)
    if (wb_ack === 1'b1 && wb_we === 1'b0)
    begin
      if (notes.size() == 0)
        check("unplanned read", 32'h1, 32'h0);
      else
      begin
        note = notes.pop_front();
        if (note.mask != 32'h0)
          check(note.what, wb_rdat & note.mask, note.exp);
      end
    end
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    logic [31:0] r;
    notes.push_back('{m, e, w});
    wb(a, 1'b0, 32'h0, r);
  endtask : rc
  // Status poll, bounded so a stuck drive ends the run
  task automatic ws(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      notes.push_back('{32'h0, 32'h0, ""});
      wb(REG_STATUS, 1'b0, 32'h0, r);
      n++;
    end
    while ((r & m) !== e && n < 200);
    check("status", r & m, e);
    if ((r & m) !== e)
      report_and_stop();
  endtask : ws
  task automatic obj(input logic [15:0] idx, input logic we, input logic [15:0] d);
    wr(REG_OBJ_INDEX, {16'h0, idx});
    wr(REG_OBJ_DATA, {16'h0, d});
    wr(REG_OBJ_CMD, {30'h0, we, 1'b1});
    ws(32'h20000, 32'h0);
  endtask : obj
  task automatic ctl(input logic [15:0] cw);
    wr(REG_CTRL, {16'h0, cw});
    repeat (3) @(posedge clk);
  endtask : ctl
  task automatic go(input logic [15:0] cw);
    wr(REG_CTRL, {16'h0, cw});
    ws(32'hffff, 32'h0337);
  endtask : go
  task automatic blk(input logic [7:0] e);
    obj(OBJ_ACTIVE, 1'b0, 16'h0);
    rc(REG_OBJ_RESULT, 32'hffffffff, {24'h0, e}, "active block");
  endtask : blk
  task automatic pulse;
    in_position <= 1'b1;
    @(posedge clk);
    in_position <= 1'b0;
    next_block <= 8'h0;
  endtask : pulse
  task automatic land(input logic [15:0] cw);
    in_position <= 1'b1;
    ws(32'hffff, 32'h0637);
    in_position <= 1'b0;
    wr(REG_CTRL, {16'h0, cw & 16'hfdff});
  endtask : land
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    {wb_cyc, wb_stb, wb_we, in_position, axis_standstill} = 5'h0;
    wb_adr = 8'h0;
    wb_wdat = 32'h0;
    wb_sel = 4'hf;
    next_block = 8'h0;
    void'($urandom(32'h7a15));
    fault_code = 16'($urandom());
    warning_code = 16'($urandom());
    sels = '{5'h0, 5'h1, 5'h2, 5'h1f, 5'($urandom_range(31))};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rc(REG_STATUS, 32'hffffffff, 32'h50, "reset status");
    rc(8'hfc, 32'hffffffff, 32'h0, "unmapped read");
    obj(OBJ_MODE, 1'b1, 16'hffff);
    rc(REG_STATUS, 32'h4ffff, 32'h40050, "early mode write");
    ctl(CW_SWITCH_ON);
    rc(REG_STATUS, 32'hffff, 32'h50, "skipped step");
    ctl(CW_DISABLE);
    wr(REG_CTRL, {16'h0, CW_SHUTDOWN});
    ws(32'hffff, 32'h0031);
    wr(REG_CTRL, {16'h0, CW_SWITCH_ON});
    ws(32'hffff, 32'h0033);
    check("power on", {31'h0, power_on}, 32'h1);
    obj(OBJ_MODE, 1'b1, 16'hffff);
    rc(REG_STATUS, 32'h40000, 32'h0, "mode write");
    obj(OBJ_MODE_DISP, 1'b0, 16'h0);
    rc(REG_OBJ_RESULT, 32'hffffffff, 32'hffff, "mode");
    obj(OBJ_DATASET, 1'b1, 16'h5);
    rc(REG_STATUS, 32'h40000, 32'h40000, "data set range");
    obj(OBJ_DATASET, 1'b1, 16'h4);
    check("data set", {29'h0, data_set}, 32'h4);
    ctl(16'h0207);
    rc(REG_STATUS, 32'hffff, 32'h33, "start while off");
    wr(REG_CTRL, {16'h0, CW_ENABLE});
    ws(32'h100ff, 32'h37);
    obj(OBJ_DATASET, 1'b1, 16'h1);
    rc(REG_STATUS, 32'h40000, 32'h40000, "locked data set");
    check("data set kept", {29'h0, data_set}, 32'h4);
    obj(OBJ_ERROR, 1'b0, 16'h0);
    rc(REG_OBJ_RESULT, 32'hffffffff, {16'h0, fault_code}, "fault");
    obj(OBJ_WARNING, 1'b0, 16'h0);
    rc(REG_OBJ_RESULT, 32'hffffffff, {16'h0, warning_code}, "warning");
    obj(16'h1000, 1'b0, 16'h0);
    rc(REG_STATUS, 32'h40000, 32'h40000, "foreign read");
    foreach (sels[i])
    begin
      go({sels[i], 11'h20f});
      check("block", {26'h0, active_block}, 32'(sels[i]) + 32'h1);
      check("moving", {31'h0, motion_enable}, 32'h1);
      land({sels[i], 11'h20f});
    end
    // Halt mid-block: target bit follows standstill, release continues the block
    go(16'h020f);
    wr(REG_CTRL, {16'h0, 16'h030f});
    axis_standstill <= 1'b1;
    ws(32'hffff, 32'h0737);
    check("halt on", {31'h0, halt_axis}, 32'h1);
    axis_standstill <= 1'b0;
    wr(REG_CTRL, {16'h0, 16'h020f});
    ws(32'hffff, 32'h0337);
    land(16'h020f);
    next_block <= 8'h2;
    go(16'h021f);
    blk(8'h1);
    pulse();
    blk(8'h2);
    land(16'h021f);
    go(16'h0a0f);
    ctl(CW_ENABLE);
    ws(32'h1ff, 32'h37);
    obj(OBJ_RESUME, 1'b0, 16'h0);
    rc(REG_OBJ_RESULT, 32'hffffffff, 32'h2, "resume point");
    ctl(16'h004f);
    go(16'h024f);
    blk(8'h2);
    land(16'h024f);
    go(16'h0a0f);
    ctl(CW_ENABLE);
    ctl(16'h005f);
    next_block <= 8'h3;
    go(16'h025f);
    pulse();
    blk(8'h3);
    land(16'h025f);
    check("halt", {31'h0, halt_axis}, 32'h0);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rc(REG_STATUS, 32'hffffffff, 32'h50, "second reset");
    wr(REG_SEQ, 32'h1);
    ws(32'h100ff, 32'h37);
    report_and_stop();
  end
endmodule : drive_table_travel_control_bench
